// ### core/adcs_core.sv
// Converter special function registers, sequencing and result capture
`timescale 1ns/1ns
//
// Contract
// - Each pin select bit makes its port-1 pin analog; all zero after reset.
// - Quiet mode bit set idles the CPU during a conversion.
// - Control bits 6..0 read zero after reset; bit 7 undefined.
// - Hardware clears convert_go at completion; it reads as busy status.
// - Divider holds a 5-bit value in bits 4..0, zero after reset.
// - High result register returns result bits 9..2.
// - Low result register returns result bits 1..0 in bits 1..0.
// - Reserved bits read undefined; software never writes them as one.
// - Converter_on clear means standby; set enables conversions.
// - Three-bit input_select picks analog input 0 to 7 in binary.
// - Converter clock is clock/64 for zero, else clock/(2*value).
// - Done flag sticks until cleared; interrupt while flag and enable both set.
module adcs_core
  import adcs_pkg::*;
(
  input  wire logic             i_clk,
  input  wire logic             i_srst,
  input  wire adcs_sfr_req_t    i_sfr,
  input  wire logic             i_converter_irq_enable,
  input  wire logic [RES_W-1:0] i_conv_result,
  output logic      [7:0]       o_sfr_rdata,
  output logic      [7:0]       o_analog_pin_bits,
  output logic      [SEL_W-1:0] o_input_select,
  output logic                  o_converter_on,
  output logic                  o_converting,
  output logic                  o_adc_clk_tick,
  output logic                  o_cpu_idle,
  output logic                  o_irq
);

  // ------------------------------------------------------------
  // Decode helpers
  // ------------------------------------------------------------
  function automatic logic sfr_write(input adcs_sfr_req_t req, input logic [7:0] addr);
    sfr_write = req.wr && (req.addr == addr);
  endfunction

  function automatic logic sfr_read(input adcs_sfr_req_t req, input logic [7:0] addr);
    sfr_read = req.rd && (req.addr == addr);
  endfunction

  // ------------------------------------------------------------
  // State
  // ------------------------------------------------------------
  adcs_ctrl_t       ctrl;
  adcs_ctrl_t       next_ctrl;
  adcs_state_t      state;
  adcs_state_t      next_state;
  logic [7:0]       pin_sel;
  logic [7:0]       next_pin_sel;
  logic [DIV_W-1:0] clk_div;
  logic [DIV_W-1:0] next_clk_div;
  logic [RES_W-1:0] result;
  logic [RES_W-1:0] next_result;
  logic [3:0]       tick_cnt;
  logic [3:0]       next_tick_cnt;
  logic [7:0]       next_rdata;
  logic             next_cpu_idle;
  logic             next_irq;
  logic [RES_W-1:0] res_meta;
  logic [RES_W-1:0] res_sync;
  logic             tick;
  logic             start_ok;
  logic             finish;
  logic [SEL_W-1:0] wr_sel;

  // ------------------------------------------------------------
  // Result input synchroniser
  // ------------------------------------------------------------
  // The analog core is not clocked by us, so its result crosses two stages
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      res_meta <= RESULT_RST;
      res_sync <= RESULT_RST;
    end else begin
      res_meta <= i_conv_result;
      res_sync <= res_meta;
    end
  end

  // ------------------------------------------------------------
  // Converter clock
  // ------------------------------------------------------------
  // Divider restarts with each conversion so every one lasts the same time
  adcs_clk_div u_div (
    .i_clk  (i_clk),
    .i_srst (i_srst),
    .i_run  (state == ST_CONV),
    .i_div  (clk_div),
    .o_tick (tick)
  );

  // ------------------------------------------------------------
  // Register and sequencer next state
  // ------------------------------------------------------------
  assign wr_sel = i_sfr.wdata[CTRL_SEL_LSB +: SEL_W];

  // A start on a pin left digital, or written with the on bit clear, has no effect
  assign start_ok = sfr_write(i_sfr, ADDR_CTRL) && i_sfr.wdata[CTRL_GO_BIT]
                    && i_sfr.wdata[CTRL_ON_BIT] && pin_sel[wr_sel]
                    && (state == ST_IDLE);

  assign finish = (state == ST_CONV) && tick && (tick_cnt == CONV_TICKS - 4'h1);

  always_comb begin
    next_ctrl     = ctrl;
    next_state    = state;
    next_pin_sel  = pin_sel;
    next_clk_div  = clk_div;
    next_result   = result;
    next_tick_cnt = tick_cnt;
    if (sfr_write(i_sfr, ADDR_PIN_SEL)) begin
      next_pin_sel = i_sfr.wdata;
    end
    if (sfr_write(i_sfr, ADDR_CLKDIV)) begin
      next_clk_div = i_sfr.wdata[DIV_W-1:0];
    end
    if (sfr_write(i_sfr, ADDR_CTRL)) begin
      next_ctrl.quiet = i_sfr.wdata[CTRL_QUIET_BIT];
      next_ctrl.on    = i_sfr.wdata[CTRL_ON_BIT];
      next_ctrl.sel   = wr_sel;
      // Software can only clear the flag; writing one keeps it as it was
      next_ctrl.done  = ctrl.done & i_sfr.wdata[CTRL_DONE_BIT];
    end
    case (state)
      ST_IDLE: begin
        if (start_ok) begin
          next_state    = ST_CONV;
          next_ctrl.go  = 1'b1;
          next_tick_cnt = 4'h0;
        end
      end
      ST_CONV: begin
        if (!next_ctrl.on) begin
          // Standby aborts a running conversion without a result
          next_state   = ST_IDLE;
          next_ctrl.go = 1'b0;
        end else if (finish) begin
          next_state   = ST_IDLE;
          next_result  = res_sync;
          next_ctrl.go = 1'b0;
          // Set after the software clear so a same-cycle clear loses
          next_ctrl.done = 1'b1;
        end else if (tick) begin
          next_tick_cnt = tick_cnt + 4'h1;
        end
      end
      default: begin
        next_state   = ST_IDLE;
        next_ctrl.go = 1'b0;
      end
    endcase
  end

  // ------------------------------------------------------------
  // Read data and outputs
  // ------------------------------------------------------------
  // Reserved bits return zero, one fixed choice for undefined values
  always_comb begin
    next_rdata = 8'h00;
    if (i_sfr.rd) begin
      case (i_sfr.addr)
        ADDR_PIN_SEL: next_rdata = pin_sel;
        ADDR_CTRL:    next_rdata = {1'b0, ctrl};
        ADDR_CLKDIV:  next_rdata = {3'h0, clk_div};
        ADDR_RES_HI:  next_rdata = result[RES_W-1:2];
        ADDR_RES_LO:  next_rdata = {6'h00, result[1:0]};
        default:      next_rdata = 8'h00;
      endcase
    end
  end

  assign next_cpu_idle = next_ctrl.quiet && next_ctrl.go;
  assign next_irq      = next_ctrl.done && i_converter_irq_enable;

  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      ctrl        <= CTRL_RST;
      state       <= ST_IDLE;
      pin_sel     <= PIN_SEL_RST;
      clk_div     <= CLKDIV_RST;
      result      <= RESULT_RST;
      tick_cnt    <= 4'h0;
      o_sfr_rdata <= 8'h00;
      o_cpu_idle  <= 1'b0;
      o_irq       <= 1'b0;
    end else begin
      ctrl        <= next_ctrl;
      state       <= next_state;
      pin_sel     <= next_pin_sel;
      clk_div     <= next_clk_div;
      result      <= next_result;
      tick_cnt    <= next_tick_cnt;
      o_sfr_rdata <= next_rdata;
      o_cpu_idle  <= next_cpu_idle;
      o_irq       <= next_irq;
    end
  end

  assign o_analog_pin_bits = pin_sel;
  assign o_input_select    = ctrl.sel;
  assign o_converter_on    = ctrl.on;
  assign o_converting      = ctrl.go;
  assign o_adc_clk_tick    = tick;

  // ------------------------------------------------------------
  // Assertions
  // ------------------------------------------------------------
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_srst);

  pin_reset_a: assert property ($past(i_srst) |-> o_analog_pin_bits == PIN_SEL_RST)
    else $error("pin select not zero after reset");

  ctrl_reset_a: assert property ($past(i_srst) |->
    (ctrl == CTRL_RST && clk_div == CLKDIV_RST))
    else $error("control or divider not zero after reset");

  quiet_idle_a: assert property ($rose(ctrl.go) && ctrl.quiet |-> o_cpu_idle)
    else $error("quiet conversion did not idle the cpu");

  idle_release_a: assert property ($fell(ctrl.go) |-> !o_cpu_idle)
    else $error("cpu idle held after conversion");

  done_finish_a: assert property (finish && next_ctrl.on |=>
    (ctrl.done && !ctrl.go && result == $past(res_sync)))
    else $error("completion did not set flag, clear go and load result");

  go_busy_a: assert property (start_ok |=> ctrl.go [*2])
    else $error("convert_go not held while converting");

  done_sticky_a: assert property (ctrl.done && !sfr_write(i_sfr, ADDR_CTRL) |=> ctrl.done)
    else $error("done flag dropped without a clear");

  irq_gate_a: assert property (
    o_irq == (ctrl.done && $past(i_converter_irq_enable)))
    else $error("interrupt not equal to flag and enable");

  standby_a: assert property (!ctrl.on |-> (!ctrl.go && state == ST_IDLE))
    else $error("conversion running in standby");

  result_hi_a: assert property (sfr_read(i_sfr, ADDR_RES_HI) |=>
    o_sfr_rdata == $past(result[RES_W-1:2]))
    else $error("high result read wrong");

  result_lo_a: assert property (sfr_read(i_sfr, ADDR_RES_LO) |=>
    o_sfr_rdata == {6'h00, $past(result[1:0])})
    else $error("low result read wrong");

  reserved_a: assert property (sfr_read(i_sfr, ADDR_CTRL) |=> !o_sfr_rdata[7])
    else $error("reserved control bit read as one");

  select_a: assert property (sfr_write(i_sfr, ADDR_CTRL) |=>
    o_input_select == $past(wr_sel))
    else $error("input select not taken from write");

  pin_write_a: assert property (sfr_write(i_sfr, ADDR_PIN_SEL) |=>
    o_analog_pin_bits == $past(i_sfr.wdata))
    else $error("pin select not taken from write");

  refuse_pin_a: assert property (sfr_write(i_sfr, ADDR_CTRL) && i_sfr.wdata[CTRL_GO_BIT]
    && !pin_sel[wr_sel] && state == ST_IDLE |=> !ctrl.go)
    else $error("start accepted on a digital pin");

  div_write_a: assert property (sfr_write(i_sfr, ADDR_CLKDIV) |=>
    clk_div == $past(i_sfr.wdata[DIV_W-1:0]))
    else $error("divider not taken from write");

  div_read_a: assert property (sfr_read(i_sfr, ADDR_CLKDIV) |=>
    o_sfr_rdata == {3'h0, $past(clk_div)})
    else $error("divider read wrong");

  go_read_a: assert property (sfr_read(i_sfr, ADDR_CTRL) |=>
    o_sfr_rdata[6:0] == $past(ctrl))
    else $error("control read does not show flags");

  no_set_a: assert property (!ctrl.done && !finish |=> !ctrl.done)
    else $error("done flag set without a completion");

  done_clear_a: assert property (sfr_write(i_sfr, ADDR_CTRL) && !finish
    && !i_sfr.wdata[CTRL_DONE_BIT] |=> !ctrl.done)
    else $error("done flag not cleared by write");

  tick_conv_a: assert property (o_adc_clk_tick |-> $past(state == ST_CONV))
    else $error("converter clock ran outside a conversion");

  abort_keep_a: assert property (state == ST_CONV && !next_ctrl.on |=>
    (!ctrl.go && result == $past(result)))
    else $error("standby abort changed the result");

  conv_done_c: cover property (finish ##1 ctrl.done);
  irq_c:       cover property ($rose(o_irq));
  abort_c:     cover property (state == ST_CONV ##1 !ctrl.on);
  quiet_c:     cover property ($rose(o_cpu_idle));
  refuse_c:    cover property (sfr_write(i_sfr, ADDR_CTRL) && i_sfr.wdata[CTRL_GO_BIT]
                               && !start_ok);

endmodule

// ### core/adcs_pkg.sv
// Constants and types shared by the converter register block
package adcs_pkg;

  // ------------------------------------------------------------
  // Register addresses
  // ------------------------------------------------------------
  localparam logic [7:0] ADDR_CLKDIV  = 8'hf2;
  localparam logic [7:0] ADDR_CTRL    = 8'hf3;
  localparam logic [7:0] ADDR_RES_LO  = 8'hf4;
  localparam logic [7:0] ADDR_RES_HI  = 8'hf5;
  localparam logic [7:0] ADDR_PIN_SEL = 8'hf6;

  // ------------------------------------------------------------
  // Control field positions
  // ------------------------------------------------------------
  localparam int CTRL_QUIET_BIT = 6;
  localparam int CTRL_ON_BIT    = 5;
  localparam int CTRL_DONE_BIT  = 4;
  localparam int CTRL_GO_BIT    = 3;
  localparam int CTRL_SEL_LSB   = 0;
  localparam int SEL_W          = 3;
  localparam int DIV_W          = 5;
  localparam int RES_W          = 10;

  // ------------------------------------------------------------
  // Reset values and counts
  // ------------------------------------------------------------
  localparam logic [7:0]       PIN_SEL_RST  = 8'h00;
  localparam logic [DIV_W-1:0] CLKDIV_RST   = 5'h00;
  localparam logic [RES_W-1:0] RESULT_RST   = 10'h000;
  localparam logic [SEL_W-1:0] SEL_RST      = 3'h0;
  localparam logic [6:0]       DIV_ZERO_PER = 7'h40;
  localparam logic [3:0]       CONV_TICKS   = 4'hb;

  // ------------------------------------------------------------
  // Types
  // ------------------------------------------------------------
  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } adcs_sfr_req_t;

  typedef struct packed {
    logic             quiet;
    logic             on;
    logic             done;
    logic             go;
    logic [SEL_W-1:0] sel;
  } adcs_ctrl_t;

  typedef enum logic [0:0] {
    ST_IDLE = 1'b0,
    ST_CONV = 1'b1
  } adcs_state_t;

  localparam adcs_ctrl_t CTRL_RST = '{quiet: 1'b0, on: 1'b0, done: 1'b0, go: 1'b0,
                                      sel: SEL_RST};

endpackage

// ### core/adcs_clk_div.sv
// Converter clock divider producing one-cycle enable pulses
`timescale 1ns/1ns
module adcs_clk_div
  import adcs_pkg::*;
(
  input  wire logic             i_clk,
  input  wire logic             i_srst,
  input  wire logic             i_run,
  input  wire logic [DIV_W-1:0] i_div,
  output logic                  o_tick
);

  // ------------------------------------------------------------
  // Divider
  // ------------------------------------------------------------
  logic [6:0] period;
  logic [5:0] cnt;
  logic [5:0] next_cnt;
  logic       next_tick;

  // Zero divide value selects the slowest rate
  assign period = (i_div == CLKDIV_RST) ? DIV_ZERO_PER : {1'b0, i_div, 1'b0};

  always_comb begin
    next_cnt  = cnt;
    next_tick = 1'b0;
    if (!i_run) begin
      next_cnt = 6'h00;
    end else if ({1'b0, cnt} == period - 7'h01) begin
      next_cnt  = 6'h00;
      next_tick = 1'b1;
    end else begin
      next_cnt = cnt + 6'h01;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      cnt    <= 6'h00;
      o_tick <= 1'b0;
    end else begin
      cnt    <= next_cnt;
      o_tick <= next_tick;
    end
  end

  // ------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------
  logic [6:0] gap;
  logic       seen;

  always_ff @(posedge i_clk) begin
    if (i_srst || !i_run) begin
      gap  <= 7'h00;
      seen <= 1'b0;
    end else if (o_tick) begin
      gap  <= 7'h01;
      seen <= 1'b1;
    end else begin
      gap <= gap + 7'h01;
    end
  end

  tick_spacing_a: assert property (@(posedge i_clk) disable iff (i_srst)
    (o_tick && seen && i_run && $stable(i_div)) |-> (gap == period))
    else $error("divider tick spacing wrong");

endmodule

// ### verification/tb_adc_sfr_control.sv
// Self-checking testbench for the converter register block
`timescale 1ns/1ns
module tb_adc_sfr_control;
  import adcs_pkg::*;

  // ------------------------------------------------------------
  // Signals
  // ------------------------------------------------------------
  logic                  i_clk;
  logic                  i_srst;
  adcs_sfr_req_t         i_sfr;
  logic                  i_converter_irq_enable;
  logic      [RES_W-1:0] i_conv_result;
  logic      [7:0]       o_sfr_rdata;
  logic      [7:0]       o_analog_pin_bits;
  logic      [SEL_W-1:0] o_input_select;
  logic                  o_converter_on;
  logic                  o_converting;
  logic                  o_adc_clk_tick;
  logic                  o_cpu_idle;
  logic                  o_irq;
  int                    failures;
  int                    n_checks;
  int                    ticks;

  adcs_core dut (
    .i_clk                  (i_clk),
    .i_srst                 (i_srst),
    .i_sfr                  (i_sfr),
    .i_converter_irq_enable (i_converter_irq_enable),
    .i_conv_result          (i_conv_result),
    .o_sfr_rdata            (o_sfr_rdata),
    .o_analog_pin_bits      (o_analog_pin_bits),
    .o_input_select         (o_input_select),
    .o_converter_on         (o_converter_on),
    .o_converting           (o_converting),
    .o_adc_clk_tick         (o_adc_clk_tick),
    .o_cpu_idle             (o_cpu_idle),
    .o_irq                  (o_irq)
  );

  // ------------------------------------------------------------
  // Clock, tick counter, watchdog
  // ------------------------------------------------------------
  initial i_clk = 1'b0;
  always #20 i_clk = ~i_clk;

  always @(posedge i_clk) begin
    if (o_adc_clk_tick === 1'b1) begin
      ticks = ticks + 1;
    end
  end

  // Longest path is the divide-by-64 conversion, about 700 cycles
  initial begin
    repeat (20000) @(posedge i_clk);
    failures++;
    summarize();
  end

  // ------------------------------------------------------------
  // Tasks
  // ------------------------------------------------------------
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    n_checks++;
    if (seen !== exp) begin
      failures++;
      $display("CHECK FAILED t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge i_clk);
    i_sfr <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(posedge i_clk);
    i_sfr <= '0;
  endtask

  // Read data is registered, so it is looked at just after the taking edge
  task automatic rdc(input logic [7:0] a, input logic [7:0] e);
    @(posedge i_clk);
    i_sfr <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
    @(posedge i_clk);
    i_sfr <= '0;
    #1;
    chk({8'h00, o_sfr_rdata}, {8'h00, e});
  endtask

  task automatic conv(input logic [4:0] div, input logic quiet, input logic [9:0] res,
                      input logic [2:0] sel);
    int n;
    int per;
    n = 0;
    per = (div == 5'h00) ? 64 : 2 * div;
    wr(ADDR_CLKDIV, {3'h0, div});
    i_conv_result <= res;
    ticks = 0;
    wr(ADDR_CTRL, {1'b0, quiet, 1'b1, 1'b0, 1'b1, sel});
    do begin
      @(posedge i_clk);
      #1;
      n++;
      if (n == 1) begin
        chk(16'(o_converting), 16'h0001);
        chk(16'(o_cpu_idle), 16'(quiet));
      end
    end while (o_converting === 1'b1 && n < 2000);
    chk(16'(n), 16'(11 * per + 1));
    chk(16'(ticks), 16'h000b);
    chk(16'(o_cpu_idle), 16'h0000);
    chk(16'(o_irq), 16'(i_converter_irq_enable));
    rdc(ADDR_CTRL, {1'b0, quiet, 1'b1, 1'b1, 1'b0, sel});
    rdc(ADDR_RES_HI, res[9:2]);
    rdc(ADDR_RES_LO, {6'h00, res[1:0]});
  endtask

  task automatic summarize();
    if (failures == 0 && n_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  // ------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------
  initial begin
    failures = 0;
    n_checks = 0;
    ticks = 0;
    i_srst = 1'b1;
    i_sfr = '0;
    i_converter_irq_enable = 1'b1;
    i_conv_result = 10'h000;
    repeat (3) @(posedge i_clk);
    i_srst <= 1'b0;
    // Reset values, unmapped address, one-cycle read data
    rdc(ADDR_PIN_SEL, 8'h00);
    rdc(ADDR_CTRL, 8'h00);
    rdc(ADDR_CLKDIV, 8'h00);
    rdc(ADDR_RES_HI, 8'h00);
    rdc(ADDR_RES_LO, 8'h00);
    rdc(8'hf1, 8'h00);
    @(posedge i_clk);
    #1;
    chk({8'h00, o_sfr_rdata}, 16'h0000);
    // Plain register access
    wr(ADDR_PIN_SEL, 8'ha5);
    rdc(ADDR_PIN_SEL, 8'ha5);
    chk({8'h00, o_analog_pin_bits}, 16'h00a5);
    wr(ADDR_CLKDIV, 8'h1f);
    rdc(ADDR_CLKDIV, 8'h1f);
    for (int s = 0; s < 8; s++) begin
      wr(ADDR_CTRL, {5'b00100, 3'(s)});
      rdc(ADDR_CTRL, {5'b00100, 3'(s)});
      chk(16'(o_input_select), 16'(s));
      chk(16'(o_converter_on), 16'h0001);
    end
    // Starts that must be refused: pin not analog, then standby
    wr(ADDR_PIN_SEL, 8'hfe);
    wr(ADDR_CTRL, 8'h28);
    repeat (3) @(posedge i_clk);
    #1;
    chk(16'(o_converting), 16'h0000);
    wr(ADDR_PIN_SEL, 8'hff);
    wr(ADDR_CTRL, 8'h08);
    repeat (3) @(posedge i_clk);
    #1;
    chk(16'(o_converting), 16'h0000);
    chk(16'(o_converter_on), 16'h0000);
    // Full conversions at several divide values
    conv(5'h01, 1'b1, 10'h2d6, 3'h5);
    @(posedge i_clk);
    i_converter_irq_enable <= 1'b0;
    @(posedge i_clk);
    #1;
    chk(16'(o_irq), 16'h0000);
    @(posedge i_clk);
    i_converter_irq_enable <= 1'b1;
    @(posedge i_clk);
    #1;
    chk(16'(o_irq), 16'h0001);
    wr(ADDR_CTRL, 8'h65);
    @(posedge i_clk);
    #1;
    chk(16'(o_irq), 16'h0000);
    rdc(ADDR_CTRL, 8'h65);
    conv(5'h00, 1'b0, 10'h129, 3'h7);
    conv(5'h1f, 1'b0, 10'h3ff, 3'h0);
    // Standby in mid-conversion aborts without a result
    wr(ADDR_CTRL, 8'h20);
    i_conv_result <= 10'h000;
    wr(ADDR_CLKDIV, 8'h02);
    wr(ADDR_CTRL, 8'h2b);
    repeat (5) @(posedge i_clk);
    wr(ADDR_CTRL, 8'h03);
    @(posedge i_clk);
    #1;
    chk(16'(o_converting), 16'h0000);
    rdc(ADDR_CTRL, 8'h03);
    chk(16'(o_irq), 16'h0000);
    rdc(ADDR_RES_HI, 8'hff);
    summarize();
  end

endmodule
